// ### rtl/ttp_glue.sv
// Board glue of a single-board trainer: halt decode, wait and bus hold,
// three 16-bit counters and the output, input and control ports.
// Assumes an APB master on pclk; all other inputs are synchronous to pclk.
//
// Notes on behaviour
// - Both CPU status lines low lights the halt indicator.
// - Outside device pulling ready low holds the CPU mid-cycle until release.
// - A halted CPU wakes only on an enabled interrupt or reset.
// - Three independent 16-bit counters, each with selectable modes.
// - Counters zero and one tick at 307.2 KHz with gates held high.
// - Counter zero output drives interrupt input five.
// - Counter one output drives the speaker.
// - Counter two output feeds control bit five, restart 7.5 and input six.
// - Counter two clock is system, ground or external; gate high or external.
// - A one written to an output bit turns on its sinking driver.
// - Control bits zero to three are outputs; bits 0-1 pick ADC channel.
// - Control bits 0-1 also clock and feed the EEPROM; bit three selects it.
// - Control bit two drives the RS-485 transmit enable.
// - Control bits four to seven are inputs; bit four low means ADC done.
// - Control bit five reads high once counter two reaches zero.
// - Bus-release jumper high requests hold; buffers float once acknowledged.
// - Expansion-type jumper routes a connector line to address strobe or ground.
// - Restart 6.5 is tied high for single stepping, else taken from expansion.
//
// The implementer's own choices: the address map and the APB register port.
`timescale 1ns/10ps
`include "ttp_consts.svh"

module ttp_glue (
	// APB slave
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// CPU status, wait and hold
	input  wire logic        cpu_status_line_zero,
	input  wire logic        cpu_status_line_one,
	input  wire logic        wait_req_n,
	input  wire logic        intr_request,
	input  wire logic        intr_enabled,
	input  wire logic        hold_ack,
	input  wire logic        bus_release_jumper,
	output logic             halt_led,
	output logic             cpu_ready,
	output logic             cpu_wake,
	output logic             hold_req,
	output logic             bus_buf_float,
	// Expansion connector
	input  wire logic        expansion_type_jumper,
	input  wire logic        addr_latch_strobe,
	input  wire logic        restart_six_half_jumper,
	input  wire logic        exp_restart_six_half,
	output logic             exp_type_line,
	output logic             restart_six_half_intr,
	// Counter outputs and counter two sources
	input  wire logic [1:0]  counter_two_clock_jumper,
	input  wire logic        counter_two_gate_jumper,
	input  wire logic        c2_ext_clk,
	input  wire logic        c2_ext_gate,
	output logic             irq_input_five,
	output logic             speaker,
	output logic             irq_input_six,
	output logic             restart_seven_half_intr,
	// Digital I/O connector
	input  wire logic [7:0]  input_dip_switch_n,
	output logic [7:0]       outport_o,
	output logic [7:0]       outport_oe,
	output logic [1:0]       adc_chan_sel,
	output logic             eeprom_clk,
	output logic             eeprom_di,
	output logic             eeprom_cs,
	output logic             rs485_tx_en,
	input  wire logic        adc_done_n,
	input  wire logic [1:0]  ctrl_aux_in
);

	logic [7:0]            outport_r;
	logic [3:0]            ctrl_r;
	logic [5:0]            tmode_r;
	logic [31:0]           prdata_r;
	logic                  pslverr_r;
	logic                  halt_led_r;
	logic                  halted_r;
	logic                  cpu_wake_r;
	logic                  cpu_ready_r;
	logic                  hold_req_r;
	logic                  float_r;
	logic                  exp_line_r;
	logic                  rst65_r;
	logic [25:0]           slow_acc_r;
	logic [25:0]           sys_acc_r;
	logic                  slow_tick_r;
	logic                  sys_tick_r;
	logic                  ext_clk_q_r;
	logic [2:0]            tick;
	logic [2:0]            gate;
	logic [2:0]            load;
	logic [2:0]            cnt_out_r;
	ttp_pkg::ttp_count_t   cnt_r [3];
	ttp_pkg::ttp_count_t   reload_r [3];
	logic                  wr_en;
	logic                  rd_en;

	// ------------------------------------------------------------------------
	// APB access
	// ------------------------------------------------------------------------
	// The slave never stretches a transfer, so every access ends at its
	// first access-phase edge.
	function automatic logic mapped(input logic [7:0] a);
		mapped = (a[1:0] == 2'h0) && (a <= `TTP_OFF_STATUS);
	endfunction

	assign wr_en = psel && penable && pwrite && mapped(paddr);
	assign rd_en = psel && !penable && !pwrite;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pslverr_r <= 1'b0;
		end else if (psel && !penable) begin
			pslverr_r <= !mapped(paddr);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r <= 32'h0000_0000;
		end else if (rd_en) begin
			unique case (paddr)
				`TTP_OFF_OUTPORT:  prdata_r <= {24'h000000, outport_r};
				`TTP_OFF_INPORT:   prdata_r <= {24'h000000, input_dip_switch_n};
				`TTP_OFF_CTRLPORT: prdata_r <= {24'h000000, ctrl_aux_in,
					cnt_out_r[2], adc_done_n, ctrl_r};
				`TTP_OFF_CNT0:     prdata_r <= {16'h0000, cnt_r[0]};
				`TTP_OFF_CNT1:     prdata_r <= {16'h0000, cnt_r[1]};
				`TTP_OFF_CNT2:     prdata_r <= {16'h0000, cnt_r[2]};
				`TTP_OFF_TMODE:    prdata_r <= {26'h0000000, tmode_r};
				`TTP_OFF_STATUS:   prdata_r <= {27'h0000000, float_r, halted_r, cnt_out_r};
				default:           prdata_r <= 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			outport_r <= `TTP_RST_OUTPORT;
		end else if (wr_en && paddr == `TTP_OFF_OUTPORT) begin
			outport_r <= pwdata[7:0];
		end
	end

	// Bits 4 to 7 have no storage: writes there are dropped.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r <= `TTP_RST_CTRL;
		end else if (wr_en && paddr == `TTP_OFF_CTRLPORT) begin
			ctrl_r <= pwdata[3:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tmode_r <= `TTP_RST_TMODE;
		end else if (wr_en && paddr == `TTP_OFF_TMODE) begin
			tmode_r <= pwdata[5:0];
		end
	end

	// ------------------------------------------------------------------------
	// CPU status, wait, hold and expansion lines
	// ------------------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			halt_led_r  <= 1'b0;
			halted_r    <= 1'b0;
			cpu_wake_r  <= 1'b0;
			cpu_ready_r <= 1'b1;
		end else begin
			halt_led_r  <= !cpu_status_line_zero && !cpu_status_line_one;
			cpu_ready_r <= wait_req_n;
			cpu_wake_r  <= halted_r && intr_request && intr_enabled;
			if (!cpu_status_line_zero && !cpu_status_line_one) begin
				halted_r <= 1'b1;
			end else if (halted_r && intr_request && intr_enabled) begin
				halted_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hold_req_r <= 1'b0;
			float_r    <= 1'b0;
			exp_line_r <= 1'b0;
			rst65_r    <= 1'b1;
		end else begin
			hold_req_r <= bus_release_jumper;
			float_r    <= bus_release_jumper && hold_ack;
			exp_line_r <= expansion_type_jumper && addr_latch_strobe;
			rst65_r    <= restart_six_half_jumper || exp_restart_six_half;
		end
	end

	// ------------------------------------------------------------------------
	// Counter clocks
	// ------------------------------------------------------------------------
	// Fractional accumulators: 50 MHz does not divide evenly, so tick spacing
	// jitters by one pclk while the mean rate is exact.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			slow_acc_r  <= 26'h0000000;
			slow_tick_r <= 1'b0;
		end else if (slow_acc_r + `TTP_SLOW_HZ >= `TTP_PCLK_HZ) begin
			slow_acc_r  <= slow_acc_r + `TTP_SLOW_HZ - `TTP_PCLK_HZ;
			slow_tick_r <= 1'b1;
		end else begin
			slow_acc_r  <= slow_acc_r + `TTP_SLOW_HZ;
			slow_tick_r <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sys_acc_r   <= 26'h0000000;
			sys_tick_r  <= 1'b0;
			ext_clk_q_r <= 1'b0;
		end else begin
			ext_clk_q_r <= c2_ext_clk;
			if (sys_acc_r + `TTP_SYS_HZ >= `TTP_PCLK_HZ) begin
				sys_acc_r  <= sys_acc_r + `TTP_SYS_HZ - `TTP_PCLK_HZ;
				sys_tick_r <= 1'b1;
			end else begin
				sys_acc_r  <= sys_acc_r + `TTP_SYS_HZ;
				sys_tick_r <= 1'b0;
			end
		end
	end

	always_comb begin
		tick[0] = slow_tick_r;
		tick[1] = slow_tick_r;
		unique case (ttp_pkg::ttp_c2clk_e'(counter_two_clock_jumper))
			ttp_pkg::TTP_C2_SYS: tick[2] = sys_tick_r;
			ttp_pkg::TTP_C2_GND: tick[2] = 1'b0;
			ttp_pkg::TTP_C2_EXT: tick[2] = c2_ext_clk && !ext_clk_q_r;
			ttp_pkg::TTP_C2_OFF: tick[2] = 1'b0;
		endcase
		gate[0] = 1'b1;
		gate[1] = 1'b1;
		gate[2] = counter_two_gate_jumper || c2_ext_gate;
	end

	// ------------------------------------------------------------------------
	// Counters
	// ------------------------------------------------------------------------
	// A load of zero leaves the counter parked at zero rather than wrapping.
	for (genvar g = 0; g < 3; g++) begin : g_cnt
		assign load[g] = wr_en && paddr == (`TTP_OFF_CNT0 + 8'(4 * g));

		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				cnt_r[g]     <= 16'h0000;
				reload_r[g]  <= 16'h0000;
				cnt_out_r[g] <= 1'b0;
			end else if (load[g]) begin
				cnt_r[g]     <= pwdata[15:0];
				reload_r[g]  <= pwdata[15:0];
				cnt_out_r[g] <= (tmode_r[2*g +: 2] != 2'h0);
			end else if (tick[g] && gate[g]) begin
				unique case (ttp_pkg::ttp_mode_e'(tmode_r[2*g +: 2]))
					ttp_pkg::TTP_TERMINAL: begin
						if (cnt_r[g] != 16'h0000) begin
							cnt_r[g] <= cnt_r[g] - 16'h0001;
						end
						if (cnt_r[g] == 16'h0001) begin
							cnt_out_r[g] <= 1'b1;
						end
					end
					ttp_pkg::TTP_RATE: begin
						if (cnt_r[g] <= 16'h0001) begin
							cnt_r[g]     <= reload_r[g];
							cnt_out_r[g] <= 1'b1;
						end else begin
							cnt_r[g]     <= cnt_r[g] - 16'h0001;
							cnt_out_r[g] <= (cnt_r[g] != 16'h0002);
						end
					end
					ttp_pkg::TTP_SQUARE: begin
						if (cnt_r[g] <= 16'h0002) begin
							cnt_r[g]     <= reload_r[g];
							cnt_out_r[g] <= !cnt_out_r[g];
						end else begin
							cnt_r[g] <= cnt_r[g] - 16'h0002;
						end
					end
					ttp_pkg::TTP_STOP: begin
						cnt_r[g] <= cnt_r[g];
					end
				endcase
			end
		end
	end

	// ------------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------------
	assign prdata                  = prdata_r;
	assign pready                  = 1'b1;
	assign pslverr                 = pslverr_r && psel && penable;
	assign halt_led                = halt_led_r;
	assign cpu_ready               = cpu_ready_r;
	assign cpu_wake                = cpu_wake_r;
	assign hold_req                = hold_req_r;
	assign bus_buf_float           = float_r;
	assign exp_type_line           = exp_line_r;
	assign restart_six_half_intr   = rst65_r;
	assign irq_input_five          = cnt_out_r[0];
	assign speaker                 = cnt_out_r[1];
	assign irq_input_six           = cnt_out_r[2];
	assign restart_seven_half_intr = cnt_out_r[2];
	// Open-collector drivers: a one sinks the line, lighting its indicator.
	assign outport_o               = 8'h00;
	assign outport_oe              = outport_r;
	assign adc_chan_sel            = ctrl_r[1:0];
	assign eeprom_clk              = ctrl_r[0];
	assign eeprom_di               = ctrl_r[1];
	assign eeprom_cs               = ctrl_r[3];
	assign rs485_tx_en             = ctrl_r[2];

	// ------------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------------
	sequence s_halt_seen;
		!cpu_status_line_zero && !cpu_status_line_one;
	endsequence

	a_halt_led_lit: assert property (@(posedge pclk) disable iff (!presetn)
		s_halt_seen |=> halt_led && halted_r)
		else $error("halt indicator not lit after halt status");

	a_wait_follows: assert property (@(posedge pclk) disable iff (!presetn)
		!wait_req_n [*2] |=> !cpu_ready [*1])
		else $error("ready released while wait held");

	a_halt_wake_only: assert property (@(posedge pclk) disable iff (!presetn)
		halted_r && !(intr_request && intr_enabled) |=> halted_r)
		else $error("halted state left without enabled interrupt");

	a_counter_load: assert property (@(posedge pclk) disable iff (!presetn)
		load[0] |=> cnt_r[0] == $past(pwdata[15:0]))
		else $error("counter zero did not take loaded value");

	a_c2_ground: assert property (@(posedge pclk) disable iff (!presetn)
		counter_two_clock_jumper == 2'h1 && !load[2] |=> $stable(cnt_r[2]))
		else $error("counter two moved with grounded clock");

	a_irq_routing: assert property (@(posedge pclk) disable iff (!presetn)
		irq_input_five == cnt_out_r[0] && speaker == cnt_out_r[1]
		&& irq_input_six == restart_seven_half_intr)
		else $error("counter outputs misrouted");

	a_ctrl_tzero: assert property (@(posedge pclk) disable iff (!presetn)
		rd_en && paddr == `TTP_OFF_CTRLPORT |=>
		prdata[`TTP_CTRL_TZERO] == $past(cnt_out_r[2]))
		else $error("control bit five does not show counter two");

	a_hold_float: assert property (@(posedge pclk) disable iff (!presetn)
		bus_release_jumper && hold_ack |=> hold_req && bus_buf_float)
		else $error("buffers not floated under hold");

	a_exp_ground: assert property (@(posedge pclk) disable iff (!presetn)
		!expansion_type_jumper |=> !exp_type_line)
		else $error("expansion line not grounded");

	a_rst65_high: assert property (@(posedge pclk) disable iff (!presetn)
		restart_six_half_jumper |=> restart_six_half_intr)
		else $error("restart 6.5 not tied high");

	a_outport_sink: assert property (@(posedge pclk) disable iff (!presetn)
		wr_en && paddr == `TTP_OFF_OUTPORT |=> outport_oe == $past(pwdata[7:0]))
		else $error("output drivers do not follow written ones");

endmodule // ttp_glue

// ### shared/ttp_consts.svh
// Constants of the trainer timer and port glue: offsets, resets, clock rates.
// Assumes byte addresses on an APB bus with 32-bit data, one word per register.
`ifndef TTP_CONSTS_SVH
`define TTP_CONSTS_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define TTP_OFF_OUTPORT  8'h00
`define TTP_OFF_INPORT   8'h04
`define TTP_OFF_CTRLPORT 8'h08
`define TTP_OFF_CNT0     8'h0C
`define TTP_OFF_CNT1     8'h10
`define TTP_OFF_CNT2     8'h14
`define TTP_OFF_TMODE    8'h18
`define TTP_OFF_STATUS   8'h1C

// ----------------------------------------------------------------------------
// Reset values and field positions
// ----------------------------------------------------------------------------
`define TTP_RST_OUTPORT  8'h00
`define TTP_RST_CTRL     4'h0
`define TTP_RST_TMODE    6'h00
`define TTP_CTRL_TZERO   5

// ----------------------------------------------------------------------------
// Clock rates in hertz
// ----------------------------------------------------------------------------
`define TTP_PCLK_HZ      26'd50000000
`define TTP_SLOW_HZ      26'd307200
`define TTP_SYS_HZ       26'd3072000

`endif

// ### shared/ttp_pkg.sv
// Types of the trainer timer and port glue.
// Assumes nothing beyond a SystemVerilog compiler.
package ttp_pkg;

	// Counter modes; the two-bit code comes straight from software.
	typedef enum logic [1:0] {
		TTP_TERMINAL,
		TTP_RATE,
		TTP_SQUARE,
		TTP_STOP
	} ttp_mode_e;

	// Sources for the clock of counter two.
	typedef enum logic [1:0] {
		TTP_C2_SYS,
		TTP_C2_GND,
		TTP_C2_EXT,
		TTP_C2_OFF
	} ttp_c2clk_e;

	typedef logic [15:0] ttp_count_t;

endpackage

// ### test/tb_top.sv
// Self-checking bench of the trainer glue: APB traffic, CPU lines, jumpers
// and counters. Assumes ttp_far_model stands on the CPU and connector side.
`timescale 1ns/10ps
`include "ttp_consts.svh"

module tb_top;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err, last_spk;
	logic [7:0]  paddr, outport_o, outport_oe, outport_line, input_dip_switch_n;
	logic [31:0] pwdata, prdata, rd;
	logic        cpu_status_line_zero, cpu_status_line_one, wait_req_n, intr_request;
	logic        intr_enabled, hold_ack, bus_release_jumper, halt_led, cpu_ready, cpu_wake;
	logic        hold_req, bus_buf_float, expansion_type_jumper, addr_latch_strobe;
	logic        restart_six_half_jumper, exp_restart_six_half, exp_type_line;
	logic        restart_six_half_intr, counter_two_gate_jumper, c2_ext_clk, c2_ext_gate;
	logic        irq_input_five, speaker, irq_input_six, restart_seven_half_intr;
	logic        eeprom_clk, eeprom_di, eeprom_cs, rs485_tx_en, adc_done_n;
	logic [1:0]  counter_two_clock_jumper, adc_chan_sel, ctrl_aux_in;
	logic [2:0]  outs;
	int          fails, compares, cycles, rises;

	assign outs = {speaker, irq_input_six, irq_input_five};

	ttp_glue ttp_glue_inst (
		.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .cpu_status_line_zero, .cpu_status_line_one, .wait_req_n, .intr_request,
		.intr_enabled, .hold_ack, .bus_release_jumper, .halt_led, .cpu_ready, .cpu_wake,
		.hold_req, .bus_buf_float, .expansion_type_jumper, .addr_latch_strobe,
		.restart_six_half_jumper, .exp_restart_six_half, .exp_type_line,
		.restart_six_half_intr, .counter_two_clock_jumper, .counter_two_gate_jumper,
		.c2_ext_clk, .c2_ext_gate, .irq_input_five, .speaker, .irq_input_six,
		.restart_seven_half_intr, .input_dip_switch_n, .outport_o, .outport_oe,
		.adc_chan_sel, .eeprom_clk, .eeprom_di, .eeprom_cs, .rs485_tx_en, .adc_done_n,
		.ctrl_aux_in
	);

	ttp_far_model #(.HOLD_LAG(3)) ttp_far_model_inst (
		.pclk, .presetn, .cpu_status_line_zero, .cpu_status_line_one, .wait_req_n,
		.intr_request, .intr_enabled, .hold_ack, .hold_req, .input_dip_switch_n,
		.adc_done_n, .ctrl_aux_in, .c2_ext_clk, .outport_o, .outport_oe, .outport_line
	);

	initial begin
		pclk = 1'h0;
		forever #10 pclk = ~pclk;
	end

	// ------------------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------------------
	task automatic complete_run();
		if (fails == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// A hang in the counter tests would otherwise run forever.
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 20000) begin
			fails++;
			complete_run();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge pclk);
		#1;
	endtask

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] rdat, output logic rerr);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'h1 && n < 50);
		if (n >= 50)
			fails++;
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'h1, a, d, rd, err);
		chk(err, 1'h0);
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'h0, a, 32'h0, rd, err);
		chk(rd, exp);
		chk(err, 1'h0);
	endtask

	task automatic wait_lvl(input int idx, input logic v, input int lim);
		int n;
		n = 0;
		while (outs[idx] !== v && n < lim) begin
			tick(1);
			n++;
		end
		chk(outs[idx], v);
	endtask

	// ------------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------------
	initial begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		presetn = 1'h0;
		{bus_release_jumper, expansion_type_jumper, addr_latch_strobe} = 3'h0;
		{restart_six_half_jumper, exp_restart_six_half} = 2'h2;
		{counter_two_clock_jumper, counter_two_gate_jumper, c2_ext_gate} = 4'h7;
		repeat (6) @(posedge pclk);
		presetn <= 1'h1;
		tick(1);
		chk({cpu_ready, restart_six_half_intr}, 2'h3);
		rdchk(`TTP_OFF_OUTPORT, 32'h0);
		rdchk(`TTP_OFF_CTRLPORT, 32'hD0);
		rdchk(`TTP_OFF_TMODE, 32'h0);
		apb(1'h1, 8'h01, 32'hFF, rd, err);
		chk(err, 1'h1);
		apb(1'h0, 8'h20, 32'h0, rd, err);
		chk(rd, 32'h0);
		chk(err, 1'h1);
		rdchk(`TTP_OFF_OUTPORT, 32'h0);
		// Data stays low from start-up; the write sets only the driver enables.
		wr(`TTP_OFF_OUTPORT, 32'hA5);
		tick(1);
		chk({outport_oe, outport_o, outport_line}, 24'hA5005A);
		rdchk(`TTP_OFF_OUTPORT, 32'hA5);
		ttp_far_model_inst.io_lines(8'h3C, 1'h0, 2'h2);
		tick(2);
		apb(1'h0, `TTP_OFF_INPORT, 32'h0, rd, err);
		chk({24'h000000, ~rd[7:0]}, 32'h3C);
		for (int v = 0; v < 16; v++) begin
			wr(`TTP_OFF_CTRLPORT, 32'hF0 | v);
			tick(1);
			chk({eeprom_cs, rs485_tx_en, eeprom_di, eeprom_clk}, v[3:0]);
			chk(adc_chan_sel, v[1:0]);
			rdchk(`TTP_OFF_CTRLPORT, 32'h80 | v);
		end
		ttp_far_model_inst.cpu_lines(2'h1, 1'h1, 1'h1, 1'h1);
		tick(2);
		chk({halt_led, cpu_wake}, 2'h0);
		ttp_far_model_inst.cpu_lines(2'h0, 1'h1, 1'h1, 1'h0);
		tick(2);
		chk({halt_led, cpu_wake}, 2'h2);
		apb(1'h0, `TTP_OFF_STATUS, 32'h0, rd, err);
		chk(rd[3], 1'h1);
		ttp_far_model_inst.cpu_lines(2'h0, 1'h1, 1'h1, 1'h1);
		tick(1);
		chk(cpu_wake, 1'h1);
		ttp_far_model_inst.cpu_lines(2'h3, 1'h0, 1'h0, 1'h0);
		tick(6);
		chk({halt_led, cpu_ready}, 2'h0);
		ttp_far_model_inst.cpu_lines(2'h3, 1'h1, 1'h0, 1'h0);
		tick(2);
		chk(cpu_ready, 1'h1);
		@(posedge pclk);
		bus_release_jumper <= 1'h1;
		tick(2);
		chk({hold_req, bus_buf_float}, 2'h2);
		tick(5);
		chk(bus_buf_float, 1'h1);
		bus_release_jumper <= 1'h0;
		tick(2);
		chk({hold_req, bus_buf_float}, 2'h0);
		for (int i = 0; i < 4; i++) begin
			@(posedge pclk);
			{expansion_type_jumper, restart_six_half_jumper} <= {2{i[1]}};
			{addr_latch_strobe, exp_restart_six_half} <= {2{i[0]}};
			tick(2);
			chk({exp_type_line, restart_six_half_intr}, {i[1] & i[0], i[1] | i[0]});
		end
		@(posedge pclk);
		counter_two_clock_jumper <= 2'h1;
		wr(`TTP_OFF_CNT2, 32'h3);
		tick(300);
		chk(irq_input_six, 1'h0);
		rdchk(`TTP_OFF_CNT2, 32'h3);
		counter_two_clock_jumper <= 2'h0;
		wr(`TTP_OFF_CNT2, 32'h3);
		tick(25);
		chk(irq_input_six, 1'h0);
		wait_lvl(1, 1'h1, 200);
		chk(restart_seven_half_intr, 1'h1);
		rdchk(`TTP_OFF_CTRLPORT, 32'hAF);
		@(posedge pclk);
		{counter_two_clock_jumper, counter_two_gate_jumper, c2_ext_gate} <= 4'h8;
		wr(`TTP_OFF_CNT2, 32'h2);
		ttp_far_model_inst.ext_pulses(3);
		chk(irq_input_six, 1'h0);
		rdchk(`TTP_OFF_CNT2, 32'h2);
		c2_ext_gate <= 1'h1;
		ttp_far_model_inst.ext_pulses(2);
		tick(2);
		chk(irq_input_six, 1'h1);
		wr(`TTP_OFF_TMODE, {28'h0, ttp_pkg::TTP_SQUARE, ttp_pkg::TTP_TERMINAL});
		wr(`TTP_OFF_CNT0, 32'h2);
		wr(`TTP_OFF_CNT1, 32'h4);
		tick(150);
		chk(irq_input_five, 1'h0);
		wait_lvl(0, 1'h1, 600);
		rises = 0;
		for (int n = 0; n < 2000; n++) begin
			last_spk = speaker;
			tick(1);
			rises += (speaker === 1'h1 && last_spk === 1'h0);
		end
		chk(rises >= 3 && rises <= 4, 1'h1);
		wr(`TTP_OFF_TMODE, {28'h0, ttp_pkg::TTP_STOP, ttp_pkg::TTP_RATE});
		wr(`TTP_OFF_CNT1, 32'h5);
		wr(`TTP_OFF_CNT0, 32'h3);
		wait_lvl(0, 1'h0, 700);
		wait_lvl(0, 1'h1, 400);
		wait_lvl(0, 1'h0, 700);
		rdchk(`TTP_OFF_CNT1, 32'h5);
		complete_run();
	end
endmodule // tb_top

// ### test/ttp_far_model.sv
// Far-side model of the trainer glue: CPU status, wait, hold and interrupt
// lines, DIP switches, ADC flag, counter two clock and pulled-up output lines.
// Assumes the bench calls its tasks from a process clocked by pclk.
`timescale 1ns/10ps

module ttp_far_model #(
	parameter int HOLD_LAG = 1
) (
	// Clock and reset
	input  wire logic       pclk,
	input  wire logic       presetn,
	// CPU side
	output logic            cpu_status_line_zero,
	output logic            cpu_status_line_one,
	output logic            wait_req_n,
	output logic            intr_request,
	output logic            intr_enabled,
	output logic            hold_ack,
	input  wire logic       hold_req,
	// Connector side
	output logic [7:0]      input_dip_switch_n,
	output logic            adc_done_n,
	output logic [1:0]      ctrl_aux_in,
	output logic            c2_ext_clk,
	input  wire logic [7:0] outport_o,
	input  wire logic [7:0] outport_oe,
	output logic [7:0]      outport_line
);
	logic [7:0] hold_sh_r;

	initial begin
		{cpu_status_line_one, cpu_status_line_zero, wait_req_n} = 3'h7;
		{intr_request, intr_enabled, c2_ext_clk} = 3'h0;
		input_dip_switch_n = 8'hFF;
		{adc_done_n, ctrl_aux_in} = 3'h7;
	end

	// Pull-ups: a line reads low only while its sinking driver is on.
	assign outport_line = (outport_oe & outport_o) | ~outport_oe;

	// The CPU needs HOLD_LAG cycles to float its bus before it acknowledges.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			hold_sh_r <= 8'h00;
		else
			hold_sh_r <= {hold_sh_r[6:0], hold_req};
	end
	assign hold_ack = hold_req & hold_sh_r[HOLD_LAG-1];

	task automatic cpu_lines(input logic [1:0] st, input logic rdy_n, input logic req,
			input logic en);
		@(posedge pclk);
		{cpu_status_line_one, cpu_status_line_zero} <= st;
		wait_req_n <= rdy_n;
		intr_request <= req;
		intr_enabled <= en;
	endtask

	// Switches closed pull their lines to ground.
	task automatic io_lines(input logic [7:0] sw_on, input logic done_n, input logic [1:0] aux);
		@(posedge pclk);
		input_dip_switch_n <= ~sw_on;
		adc_done_n <= done_n;
		ctrl_aux_in <= aux;
	endtask

	// The external clock stands low between pulses.
	task automatic ext_pulses(input int n);
		repeat (n) begin
			@(posedge pclk);
			c2_ext_clk <= 1'h1;
			repeat (4) @(posedge pclk);
			c2_ext_clk <= 1'h0;
			repeat (4) @(posedge pclk);
		end
	endtask
endmodule // ttp_far_model
